//--- verilog/iaf_pkg.sv
package iaf_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PTR = 3;
  localparam int FLAG_W = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Address map: pointer n owns eight addresses from PTR_GRP_BASE + n * stride
  localparam logic [11:0] PTR_GRP_BASE = 12'hFD0;
  localparam logic [11:0] PTR_GRP_STRIDE = 12'h008;
  localparam logic [11:0] FLAGS_ADDR = 12'hFE8;
  localparam logic [2:0] SLOT_DEREF = 3'h0;
  localparam logic [2:0] SLOT_DOWN = 3'h1;
  localparam logic [2:0] SLOT_UP = 3'h2;
  localparam logic [2:0] SLOT_PREUP = 3'h3;
  localparam logic [2:0] SLOT_INDEX = 3'h4;
  localparam logic [2:0] SLOT_HIGH = 3'h5;
  localparam logic [2:0] SLOT_LOW = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag positions and reset values
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [4:0] MASK_ARITH = 5'h1F;
  localparam logic [4:0] MASK_LOGIC = 5'h14;
  localparam logic [4:0] MASK_ROT = 5'h17;
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [11:0] PTR_STEP = 12'h001;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [3:0] HIGH_PAD = 4'h0;
  localparam logic [2:0] FLAGS_PAD = 3'h0;

  typedef enum logic [2:0] {
    ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC
  } iaf_alu_e;

  typedef enum logic [3:0] {
    KIND_PLAIN, KIND_DEREF, KIND_DOWN, KIND_UP, KIND_PREUP, KIND_INDEX,
    KIND_HIGH, KIND_LOW, KIND_FLAGS
  } iaf_kind_e;

  typedef struct packed {
    iaf_kind_e kind;
    logic [1:0] idx;
  } iaf_dec_s;

  typedef struct packed {
    logic [7:0] res;
    logic [4:0] flags;
    logic [4:0] mask;
  } iaf_alu_s;

  function automatic iaf_dec_s iaf_decode(input logic [11:0] addr);
    iaf_dec_s d;
    logic [11:0] base;
    d.kind = (addr == FLAGS_ADDR) ? KIND_FLAGS : KIND_PLAIN;
    d.idx = 2'h0;
    base = PTR_GRP_BASE;
    for (int n = 0; n < NUM_PTR; n++) begin
      if (addr[11:3] == base[11:3]) begin
        d.idx = 2'(n);
        case (addr[2:0])
          SLOT_DEREF: d.kind = KIND_DEREF;
          SLOT_DOWN: d.kind = KIND_DOWN;
          SLOT_UP: d.kind = KIND_UP;
          SLOT_PREUP: d.kind = KIND_PREUP;
          SLOT_INDEX: d.kind = KIND_INDEX;
          SLOT_HIGH: d.kind = KIND_HIGH;
          SLOT_LOW: d.kind = KIND_LOW;
          default: d.kind = KIND_PLAIN;
        endcase
      end
      base = base + PTR_GRP_STRIDE;
    end
    return d;
  endfunction : iaf_decode

  function automatic logic iaf_is_port(input iaf_kind_e k);
    return (k == KIND_DEREF) || (k == KIND_DOWN) || (k == KIND_UP) ||
           (k == KIND_PREUP) || (k == KIND_INDEX);
  endfunction : iaf_is_port

endpackage : iaf_pkg

//--- verilog/iaf_core.sv
// Implementation choices: the address-and-strobe port and the register addresses.
module iaf_core
  import iaf_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] accumulator_in,
  input wire iaf_alu_e alu_op_in,
  input wire logic [7:0] alu_a_in,
  input wire logic [7:0] alu_b_in,
  input wire logic [7:0] ram_rdata_in,
  output logic [7:0] rdata_out,
  output logic [7:0] alu_result_out,
  output logic [7:0] alu_flags_out,
  output logic [11:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  output logic ram_we_out,
  output logic ram_re_out
);

  typedef struct packed {
    logic [NUM_PTR-1:0][11:0] pointer_reg;
    logic [4:0] flags;
    logic [7:0] rdata;
    logic rd_ram;
    logic [11:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    logic ram_re;
    logic [7:0] alu_res;
  } iaf_state_s;

  iaf_state_s s_q;
  iaf_state_s s_d;

  // One adder serves add and subtract so both see identical carry logic
  function automatic iaf_alu_s iaf_add(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    iaf_alu_s r;
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.res = sum[7:0];
    r.flags = '0;
    r.flags[FLAG_C] = sum[8];
    r.flags[FLAG_DC] = low[4];
    r.flags[FLAG_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
    r.mask = MASK_ARITH;
    return r;
  endfunction : iaf_add

  function automatic iaf_alu_s iaf_alu(input iaf_alu_e op, input logic [7:0] a,
                                       input logic [7:0] b, input logic c);
    iaf_alu_s r;
    r.res = DATA_ZERO;
    r.flags = '0;
    r.mask = MASK_NONE;
    case (op)
      ALU_ADD: r = iaf_add(a, b, 1'b0);
      ALU_SUB: r = iaf_add(a, ~b, 1'b1);
      ALU_AND: begin
        r.res = a & b;
        r.mask = MASK_LOGIC;
      end
      ALU_OR: begin
        r.res = a | b;
        r.mask = MASK_LOGIC;
      end
      ALU_XOR: begin
        r.res = a ^ b;
        r.mask = MASK_LOGIC;
      end
      ALU_RLC: begin
        r.res = {a[6:0], c};
        r.flags[FLAG_C] = a[7];
        r.flags[FLAG_DC] = a[3];
        r.mask = MASK_ROT;
      end
      ALU_RRC: begin
        r.res = {c, a[7:1]};
        r.flags[FLAG_C] = a[0];
        r.flags[FLAG_DC] = a[4];
        r.mask = MASK_ROT;
      end
      default: r.mask = MASK_NONE;
    endcase
    r.flags[FLAG_N] = r.res[7];
    r.flags[FLAG_Z] = (r.res == DATA_ZERO);
    return r;
  endfunction : iaf_alu

  ////////////////////////////////////////////////////////////////////////////////
  // Address resolution and state update
  always_comb begin
    iaf_dec_s src;
    iaf_dec_s tgt;
    logic [11:0] cur;
    logic [11:0] eff;
    logic [11:0] stepped;
    logic step;
    logic indirect;
    logic virt;
    logic ptr_tgt;
    logic [4:0] f;
    iaf_alu_s alu;
    src = iaf_decode(addr_in);
    cur = s_q.pointer_reg[src.idx];
    eff = addr_in;
    stepped = cur;
    step = 1'b0;
    s_d = s_q;
    s_d.rd_ram = 1'b0;
    s_d.ram_we = 1'b0;
    s_d.ram_re = 1'b0;
    s_d.rdata = DATA_ZERO;
    indirect = iaf_is_port(src.kind);
    // Wrap falls out of 12-bit arithmetic, so steps carry across bytes
    case (src.kind)
      KIND_DEREF: eff = cur;
      KIND_DOWN: begin
        eff = cur;
        stepped = cur - PTR_STEP;
        step = 1'b1;
      end
      KIND_UP: begin
        eff = cur;
        stepped = cur + PTR_STEP;
        step = 1'b1;
      end
      KIND_PREUP: begin
        eff = cur + PTR_STEP;
        stepped = eff;
        step = 1'b1;
      end
      KIND_INDEX: eff = cur + {{4{accumulator_in[7]}}, accumulator_in};
      default: eff = addr_in;
    endcase
    tgt = iaf_decode(eff);
    virt = indirect && iaf_is_port(tgt.kind);
    ptr_tgt = (tgt.kind == KIND_HIGH) || (tgt.kind == KIND_LOW);
    // Stepping only writes the pointer, never the flags
    if ((rd_in || wr_in) && step && !(wr_in && ptr_tgt) && !(wr_in && virt)) begin
      s_d.pointer_reg[src.idx] = stepped;
    end
    if (wr_in && !virt) begin
      case (tgt.kind)
        KIND_HIGH: s_d.pointer_reg[tgt.idx][11:8] = wdata_in[3:0];
        KIND_LOW: s_d.pointer_reg[tgt.idx][7:0] = wdata_in;
        KIND_FLAGS: ;
        default: begin
          s_d.ram_we = 1'b1;
          s_d.ram_addr = eff;
          s_d.ram_wdata = wdata_in;
        end
      endcase
    end
    if (rd_in) begin
      if (virt) begin
        s_d.rdata = DATA_ZERO;
      end else begin
        case (tgt.kind)
          KIND_HIGH: s_d.rdata = {HIGH_PAD, s_q.pointer_reg[tgt.idx][11:8]};
          KIND_LOW: s_d.rdata = s_q.pointer_reg[tgt.idx][7:0];
          KIND_FLAGS: s_d.rdata = {FLAGS_PAD, s_q.flags};
          default: begin
            s_d.rd_ram = 1'b1;
            s_d.ram_re = 1'b1;
            s_d.ram_addr = eff;
          end
        endcase
      end
    end
    alu = iaf_alu(alu_op_in, alu_a_in, alu_b_in, s_q.flags[FLAG_C]);
    if (alu_op_in != ALU_NONE) begin
      s_d.alu_res = alu.res;
    end
    f = s_q.flags;
    if (wr_in && !virt && tgt.kind == KIND_FLAGS) begin
      f = wdata_in[4:0];
    end
    // A write that lands on a port cancels the ALU flag update, but not the Z that a port read in the same cycle sets
    if (!(wr_in && virt)) begin
      f = (f & ~alu.mask) | (alu.flags & alu.mask);
    end
    if (rd_in && virt) begin
      f[FLAG_Z] = 1'b1;
    end
    s_d.flags = f;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.pointer_reg <= {NUM_PTR{PTR_RST}};
      s_q.flags <= FLAGS_RST;
      s_q.rdata <= DATA_ZERO;
      s_q.rd_ram <= 1'b0;
      s_q.ram_addr <= PTR_RST;
      s_q.ram_wdata <= DATA_ZERO;
      s_q.ram_we <= 1'b0;
      s_q.ram_re <= 1'b0;
      s_q.alu_res <= DATA_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; RAM read is combinational, so its byte is steered not re-latched
  assign rdata_out = s_q.rd_ram ? ram_rdata_in : s_q.rdata;
  assign alu_result_out = s_q.alu_res;
  assign alu_flags_out = {FLAGS_PAD, s_q.flags};
  assign ram_addr_out = s_q.ram_addr;
  assign ram_wdata_out = s_q.ram_wdata;
  assign ram_we_out = s_q.ram_we;
  assign ram_re_out = s_q.ram_re;

endmodule : iaf_core

//--- dv/iaf_core_checker.sv
module iaf_core_checker
  import iaf_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire iaf_alu_e alu_op_in,
  input wire logic [7:0] alu_a_in,
  input wire logic [7:0] alu_b_in,
  input wire logic [7:0] ram_rdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] alu_result_out,
  input wire logic [7:0] alu_flags_out,
  input wire logic [11:0] ram_addr_out,
  input wire logic [7:0] ram_wdata_out,
  input wire logic ram_we_out,
  input wire logic ram_re_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Every address below the pointer group is plain RAM, so no decode is needed here
  wire logic ram = addr_in < PTR_GRP_BASE;
  wire logic busy = wr_in || rd_in;
  wire logic op = alu_op_in != ALU_NONE;
  a_ram_read: assert property (
    rd_in && ram |=> ram_re_out && ram_addr_out == $past(addr_in) && rdata_out == ram_rdata_in)
    else $error("ram read");
  a_ram_write: assert property (
    wr_in && ram |=> ram_we_out && ram_addr_out == $past(addr_in) &&
      ram_wdata_out == $past(wdata_in)) else $error("ram write");
  a_top_zero: assert property (alu_flags_out[7:5] == 3'h0) else $error("top bits");
  a_sign_bit: assert property (
    op && !wr_in |=> alu_flags_out[FLAG_N] == alu_result_out[7]) else $error("sign");
  a_zero_bit: assert property (
    op && !busy |=> alu_flags_out[FLAG_Z] == (alu_result_out == 8'h00)) else $error("zero");
  a_add_carry: assert property (
    alu_op_in == ALU_ADD && !wr_in |=>
      {alu_flags_out[FLAG_C], alu_result_out} == {1'b0, $past(alu_a_in)} + $past(alu_b_in))
    else $error("add carry");
  a_sub_borrow: assert property (
    alu_op_in == ALU_SUB && !wr_in |=>
      alu_flags_out[FLAG_C] == ($past(alu_a_in) >= $past(alu_b_in))) else $error("borrow");
  a_flags_hold: assert property (
    !op && !busy |=> $stable(alu_flags_out)) else $error("flags moved");
endmodule : iaf_core_checker

bind iaf_core iaf_core_checker i_chk (.*);

//--- dv/iaf_ram_model.sv
module iaf_ram_model (
  input wire logic clock_in,
  input wire logic [11:0] addr_in,
  input wire logic re_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem[4096];
  logic [7:0] last = 8'h00;
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'hA5;
  // Released bus shows the inverse of its last value, never a stale copy
  always_comb rdata_out = re_in ? mem[addr_in] : ~last;
  always @(posedge clock_in) begin
    last <= rdata_out;
    if (we_in) mem[addr_in] <= wdata_in;
  end
endmodule : iaf_ram_model

//--- dv/tb_iaf_core.sv
module tb_iaf_core
  import iaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [7:0] wdata_in = 8'h00, accumulator_in = 8'h00, alu_a_in = 8'h00, alu_b_in = 8'h00;
  iaf_alu_e alu_op_in = ALU_NONE;
  logic [7:0] ram_rdata_in, rdata_out, alu_result_out, alu_flags_out, ram_wdata_out, rd_q;
  logic [11:0] ram_addr_out, ra_q;
  logic ram_we_out, ram_re_out;
  int err_count = 0, checks = 0;
  always #20 clock_in = ~clock_in;
  iaf_core i_dut (.*);
  iaf_ram_model i_ram (.clock_in, .addr_in(ram_addr_out), .re_in(ram_re_out),
    .we_in(ram_we_out), .wdata_in(ram_wdata_out), .rdata_out(ram_rdata_in));
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // Strobes drop on the edge and rise 1 ns later, so back-to-back calls never collide
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] c = 8'h00);
    addr_in <= a;
    accumulator_in <= c;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    rd_q = rdata_out;
    ra_q = ram_addr_out;
  endtask : rd
  task automatic wr_op(input logic [11:0] a, input logic [7:0] d, input iaf_alu_e op);
    alu_op_in <= op;
    alu_a_in <= 8'h7F;
    alu_b_in <= 8'h01;
    wr(a, d);
    alu_op_in <= ALU_NONE;
  endtask : wr_op
  task automatic t_modes;
    logic [2:0] s[8] = '{3'h2, 3'h0, 3'h1, 3'h0, 3'h3, 3'h4, 3'h4, 3'h0};
    logic [7:0] c[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'h00};
    logic [11:0] e[8] = '{12'h100, 12'h101, 12'h101, 12'h100,
      12'h101, 12'h100, 12'h180, 12'h101};
    wr(12'hFD5, 8'h01);
    wr(12'hFD6, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(PTR_GRP_BASE | 12'(s[i]), c[i]);
      chk("pointer addr", e[i], ra_q);
    end
    chk("ram data", 12'h0A4, rd_q);
    wr(12'h050, 8'h3C);
    rd(12'h050);
    chk("direct data", 12'h03C, rd_q);
  endtask : t_modes
  task automatic t_wrap;
    wr(12'hFDD, 8'h0F);
    wr(12'hFDE, 8'hFF);
    rd(12'hFDA);
    chk("top addr", 12'hFFF, ra_q);
    rd(12'hFD9);
    chk("wrap up", 12'h000, ra_q);
    rd(12'hFD8);
    chk("wrap down", 12'hFFF, ra_q);
    rd(FLAGS_ADDR);
    chk("flags", 12'h000, rd_q);
  endtask : t_wrap
  task automatic t_virtual;
    wr(12'hFE5, 8'h0F);
    wr(12'hFE6, 8'hD0);
    rd(12'hFE0);
    chk("port read", 12'h000, rd_q);
    rd(FLAGS_ADDR);
    chk("flags", 12'h004, rd_q);
    wr_op(12'hFE0, 8'hAA, ALU_ADD);
    chk("port write", 12'h000, ram_we_out);
    rd(FLAGS_ADDR);
    chk("flags", 12'h004, rd_q);
    wr(12'hFE6, 8'hD6);
    wr(12'hFE2, 8'h55);
    rd(12'hFE0);
    chk("byte write", 12'h055, rd_q);
    rd(12'hFD0);
    chk("byte addr", 12'h155, ra_q);
  endtask : t_virtual
  task automatic t_alu;
    iaf_alu_e op[8] = '{ALU_ADD, ALU_SUB, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC};
    logic [7:0] a[8] = '{8'h7F, 8'h05, 8'h00, 8'hF0, 8'h80, 8'hFF, 8'h88, 8'h01};
    logic [7:0] b[8] = '{8'h01, 8'h05, 8'h01, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'h00};
    logic [7:0] f[8] = '{8'h1A, 8'h07, 8'h10, 8'h04, 8'h10, 8'h04, 8'h03, 8'h11};
    for (int i = 0; i < 8; i++) begin
      alu_op_in <= op[i];
      alu_a_in <= a[i];
      alu_b_in <= b[i];
      @(posedge clock_in);
      alu_op_in <= ALU_NONE;
      #1;
      rd(FLAGS_ADDR);
      chk("flags", {4'h0, f[i]}, {4'h0, rd_q});
    end
    wr_op(FLAGS_ADDR, 8'hFF, ALU_SUB);
    rd(FLAGS_ADDR);
    // 7F - 01 carries out of bit 3 and bit 7, so both carry flags read one
    chk("masked write", 12'h003, rd_q);
    wr(FLAGS_ADDR, 8'hFF);
    rd(FLAGS_ADDR);
    chk("top bits", 12'h01F, rd_q);
  endtask : t_alu
  task automatic complete_run;
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2000) @(posedge clock_in);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    #1;
    t_wrap();
    t_modes();
    t_virtual();
    t_alu();
    complete_run();
  end
endmodule : tb_iaf_core
